// [his_regs.svh]
// register offsets, field positions and reset values of the interrupt status block
`ifndef HIS_REGS_SVH
`define HIS_REGS_SVH
`define HIS_A_TOP 8'h00
`define HIS_A_TOPM 8'h04
`define HIS_A_BST 8'h08
`define HIS_A_BEX 8'h0C
`define HIS_A_BMSK 8'h10
`define HIS_A_BCMD 8'h14
`define HIS_A_DST 8'h18
`define HIS_A_DEX 8'h1C
`define HIS_A_DMSK 8'h20
`define HIS_A_DCMD 8'h24
`define HIS_A_CI_RECEIVE_REG0 8'h28
`define HIS_A_CI_RECEIVE_REG1 8'h2C
`define HIS_A_FEAT 8'h30
`define HIS_TOP_DINT 0
`define HIS_TOP_DEXT 1
`define HIS_TOP_BINT 2
`define HIS_TOP_BEXT 3
`define HIS_B_XPR 0
`define HIS_B_XMR 1
`define HIS_B_XDU 2
`define HIS_D_RPF 7
`define HIS_D_RME 6
`define HIS_D_RSC 5
`define HIS_D_XPR 4
`define HIS_D_TIN 3
`define HIS_D_CIC 2
`define HIS_D_SECOND_TIMER_EXPIRY 1
`define HIS_X_XMR 7
`define HIS_X_XDU 6
`define HIS_X_RFO 4
`define HIS_X_PCE 3
`define HIS_C_TRANSMITTER_RESET_CMD 0
`define HIS_C_SEND 1
`define HIS_C_XME 2
`define HIS_C_RMC 3
`define HIS_F_CI_CHAN1_CHANGE_ENABLE 0
`define HIS_F_AUTO 1
`define HIS_F_TERM 2
`define HIS_MASK_RST 8'h00
`define HIS_FEAT_RST 8'h00
`endif

// [his_pkg.sv]
// types shared by the interrupt status block
package his_pkg;
  typedef enum logic [1:0] {
    HIS_TX_IDLE = 2'b00,
    HIS_TX_SEND = 2'b01,
    HIS_TX_EOM = 2'b10
  } his_tx_state_t;
endpackage

// [his_flags.sv]
// eight sticky status flags, set wins over clear
`timescale 1ns/1ps
module his_flags (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] set,
  input wire logic [7:0] clr,
  output logic [7:0] q
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= 8'h00;
    else
      q <= (q & ~clr) | set;
  end
endmodule

// [his_ci_buf.sv]
// two-deep buffer for one received command/indication code
`timescale 1ns/1ps
module his_ci_buf (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] code_in,
  input wire logic code_rd,
  input wire logic flag_clr,
  output logic [3:0] code_q,
  output logic change_q
);
  logic [3:0] last_q;
  logic [3:0] pend_q;
  logic pend_v_q;
  logic unread_q;
  logic newc;
  logic take;
  logic chg_set;
  assign newc = code_in != last_q;
  assign take = code_rd & unread_q;
  // a read frees the register; a waiting code loads and flags again at once
  assign chg_set = (take & (pend_v_q | newc)) | (newc & ~unread_q);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_q <= 4'h0;
      code_q <= 4'h0;
      pend_q <= 4'h0;
      pend_v_q <= 1'b0;
      unread_q <= 1'b0;
    end
    else
    begin
      last_q <= code_in;
      if (take && pend_v_q)
      begin
        code_q <= pend_q;
        pend_v_q <= newc;
        if (newc)
          pend_q <= code_in;
      end
      else if (take && newc)
        code_q <= code_in;
      else if (take)
        unread_q <= 1'b0;
      else if (newc && !unread_q)
      begin
        code_q <= code_in;
        unread_q <= 1'b1;
      end
      else if (newc)
      begin
        // later codes overwrite, so only first and last survive
        pend_q <= code_in;
        pend_v_q <= 1'b1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      change_q <= 1'b0;
    else
      change_q <= chg_set | (change_q & ~flag_clr);
  end
endmodule

// [his_top.sv]
// hdlc interrupt status block with apb register access
`timescale 1ns/1ps
`include "his_regs.svh"
module his_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic b_pool_empty_evt,
  input wire logic b_frame_done_evt,
  input wire logic b_drained_evt,
  input wire logic b_repeat_evt,
  input wire logic d_rx_pool_full_evt,
  input wire logic d_rx_msg_end_evt,
  input wire logic d_rx_overflow_evt,
  input wire logic d_proto_err_evt,
  input wire logic d_pool_free_evt,
  input wire logic d_peer_ack_evt,
  input wire logic d_tx_error_evt,
  input wire logic d_peer_nack_evt,
  input wire logic d_fifo_empty_evt,
  input wire logic d_frame_done_evt,
  input wire logic d_peer_status_evt,
  input wire logic d_ext_timer_evt,
  input wire logic d_t200_exp,
  input wire logic d_n200_exp,
  input wire logic d_timer2_evt,
  input wire logic [3:0] ci0_code,
  input wire logic [3:0] ci1_code,
  output logic int_n,
  output logic b_tx_reset,
  output logic d_frame_abort,
  output logic d_rx_release
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  function automatic logic at(input logic [7:0] a, input logic [7:0] r);
    at = a == r;
  endfunction

  logic acc;
  logic done;
  logic wr;
  logic rd;
  logic hit;
  logic [31:0] rd_d;
  logic [7:0] top_mask_q;
  logic [7:0] b_mask_q;
  logic [7:0] d_mask_q;
  logic [7:0] feat_q;
  logic [7:0] b_set;
  logic [7:0] b_clr;
  logic [7:0] b_pend;
  logic [7:0] d_set;
  logic [7:0] d_clr;
  logic [7:0] d_flags;
  logic [7:0] d_pend;
  logic [7:0] x_set;
  logic [7:0] x_clr;
  logic [7:0] x_pend;
  logic [7:0] b_shown;
  logic [7:0] d_shown;
  logic [3:0] top_raw;
  logic [3:0] top_shown;
  logic [3:0] ci0_q;
  logic [3:0] ci1_q;
  logic ci0_chg;
  logic ci1_chg;
  logic ci1_vis;
  logic auto_m;
  logic wr_bcmd;
  logic wr_dcmd;
  logic rd_ci_receive_reg0;
  his_pkg::his_tx_state_t b_st_q;
  logic d_send_q;
  logic d_eom_q;
  logic d_ieom_q;
  logic d_abort_set;
  logic irq_due;

  // two-cycle access: data captured in the first access cycle, pready in the second
  assign acc = psel & penable;
  assign done = acc & pready;
  assign wr = done & pwrite & ~pslverr;
  assign rd = done & ~pwrite & ~pslverr;
  assign hit = (paddr[1:0] == 2'b00) && (paddr <= `HIS_A_FEAT);
  assign auto_m = feat_q[`HIS_F_AUTO];
  assign wr_bcmd = wr & at(paddr, `HIS_A_BCMD);
  assign wr_dcmd = wr & at(paddr, `HIS_A_DCMD);
  assign rd_ci_receive_reg0 = rd & at(paddr, `HIS_A_CI_RECEIVE_REG0);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~hit;
      if (acc && !pready)
        prdata <= (pwrite || !hit) ? 32'h0000_0000 : rd_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      top_mask_q <= `HIS_MASK_RST;
      b_mask_q <= `HIS_MASK_RST;
      d_mask_q <= `HIS_MASK_RST;
      feat_q <= `HIS_FEAT_RST;
    end
    else if (wr)
    begin
      if (at(paddr, `HIS_A_TOPM))
        top_mask_q <= pwdata[7:0];
      if (at(paddr, `HIS_A_BMSK))
        b_mask_q <= pwdata[7:0];
      if (at(paddr, `HIS_A_DMSK))
        d_mask_q <= pwdata[7:0];
      if (at(paddr, `HIS_A_FEAT))
        feat_q <= pwdata[7:0];
    end
  end

  // b channel transmit frame tracking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      b_st_q <= his_pkg::HIS_TX_IDLE;
    else if (wr_bcmd && pwdata[`HIS_C_TRANSMITTER_RESET_CMD])
      b_st_q <= his_pkg::HIS_TX_IDLE;
    else if (wr_bcmd && pwdata[`HIS_C_SEND])
      b_st_q <= pwdata[`HIS_C_XME] ? his_pkg::HIS_TX_EOM : his_pkg::HIS_TX_SEND;
    else
    begin
      case (b_st_q)
        his_pkg::HIS_TX_SEND:
        begin
          if (wr_bcmd && pwdata[`HIS_C_XME])
            b_st_q <= his_pkg::HIS_TX_EOM;
          else if (b_drained_evt)
            b_st_q <= his_pkg::HIS_TX_IDLE;
        end
        his_pkg::HIS_TX_EOM:
        begin
          if (b_frame_done_evt)
            b_st_q <= his_pkg::HIS_TX_IDLE;
        end
        default:
          b_st_q <= his_pkg::HIS_TX_IDLE;
      endcase
    end
  end

  always_comb
  begin
    b_set = 8'h00;
    b_set[`HIS_B_XPR] = (wr_bcmd & pwdata[`HIS_C_TRANSMITTER_RESET_CMD])
      | (b_st_q == his_pkg::HIS_TX_SEND & b_pool_empty_evt)
      | (b_st_q == his_pkg::HIS_TX_EOM & b_frame_done_evt);
    b_set[`HIS_B_XMR] = b_repeat_evt;
    b_set[`HIS_B_XDU] = b_st_q == his_pkg::HIS_TX_SEND & b_drained_evt
      & ~(wr_bcmd & pwdata[`HIS_C_XME]);
    b_clr = 8'h00;
    // a read clears exactly what it showed, so later events survive
    if (rd && at(paddr, `HIS_A_BST))
      b_clr[`HIS_B_XPR] = prdata[`HIS_B_XPR];
    if (rd && at(paddr, `HIS_A_BEX))
    begin
      b_clr[`HIS_B_XMR] = prdata[`HIS_B_XMR];
      b_clr[`HIS_B_XDU] = prdata[`HIS_B_XDU];
    end
  end

  his_flags u_b_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set(b_set),
    .clr(b_clr),
    .q(b_pend)
  );

  // d channel transmit state for underrun and peer acknowledgement
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      d_send_q <= 1'b0;
      d_eom_q <= 1'b0;
      d_ieom_q <= 1'b0;
    end
    else if (wr_dcmd && pwdata[`HIS_C_TRANSMITTER_RESET_CMD])
    begin
      d_send_q <= 1'b0;
      d_eom_q <= 1'b0;
      d_ieom_q <= 1'b0;
    end
    else
    begin
      if (wr_dcmd && pwdata[`HIS_C_SEND])
        d_send_q <= 1'b1;
      else if (d_abort_set || d_frame_done_evt)
        d_send_q <= 1'b0;
      if (wr_dcmd && pwdata[`HIS_C_XME])
        d_eom_q <= 1'b1;
      else if (d_abort_set || d_frame_done_evt)
        d_eom_q <= 1'b0;
      if (wr_dcmd && pwdata[`HIS_C_SEND] && pwdata[`HIS_C_XME] && auto_m)
        d_ieom_q <= 1'b1;
      else if (d_peer_ack_evt)
        d_ieom_q <= 1'b0;
    end
  end

  assign d_abort_set = d_send_q & ~d_eom_q & d_fifo_empty_evt
    & ~(wr_dcmd & pwdata[`HIS_C_XME]);

  always_comb
  begin
    d_set = 8'h00;
    d_set[`HIS_D_RPF] = d_rx_pool_full_evt;
    d_set[`HIS_D_RME] = d_rx_msg_end_evt;
    d_set[`HIS_D_RSC] = auto_m & d_peer_status_evt;
    d_set[`HIS_D_XPR] = d_pool_free_evt | (auto_m & d_ieom_q & d_peer_ack_evt);
    d_set[`HIS_D_TIN] = d_ext_timer_evt | (auto_m & d_t200_exp & d_n200_exp);
    d_set[`HIS_D_SECOND_TIMER_EXPIRY] = d_timer2_evt;
    d_clr = 8'h00;
    if (rd && at(paddr, `HIS_A_DST))
      d_clr = prdata[7:0] & ~(8'h01 << `HIS_D_CIC);
    x_set = 8'h00;
    x_set[`HIS_X_XMR] = d_tx_error_evt | (auto_m & d_peer_nack_evt);
    x_set[`HIS_X_XDU] = d_abort_set;
    x_set[`HIS_X_RFO] = d_rx_overflow_evt;
    x_set[`HIS_X_PCE] = auto_m & d_proto_err_evt;
    x_clr = 8'h00;
    if (rd && at(paddr, `HIS_A_DEX))
      x_clr = prdata[7:0];
  end

  his_flags u_d_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set(d_set),
    .clr(d_clr),
    .q(d_flags)
  );

  his_flags u_x_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set(x_set),
    .clr(x_clr),
    .q(x_pend)
  );

  // both change bits clear on a code-0 read; a hidden channel 1 change is kept
  assign ci1_vis = feat_q[`HIS_F_CI_CHAN1_CHANGE_ENABLE] & feat_q[`HIS_F_TERM];

  his_ci_buf u_ci0 (
    .pclk(pclk),
    .presetn(presetn),
    .code_in(ci0_code),
    .code_rd(rd_ci_receive_reg0),
    .flag_clr(rd_ci_receive_reg0),
    .code_q(ci0_q),
    .change_q(ci0_chg)
  );

  his_ci_buf u_ci1 (
    .pclk(pclk),
    .presetn(presetn),
    .code_in(ci1_code),
    .code_rd(rd & at(paddr, `HIS_A_CI_RECEIVE_REG1)),
    .flag_clr(rd_ci_receive_reg0 & ci1_vis),
    .code_q(ci1_q),
    .change_q(ci1_chg)
  );

  always_comb
  begin
    d_pend = d_flags;
    d_pend[`HIS_D_CIC] = ci0_chg | (ci1_chg & ci1_vis);
    b_shown = b_pend & ~b_mask_q;
    // the change bit shows even when masked
    d_shown = (d_pend & ~d_mask_q) | (d_pend & (8'h01 << `HIS_D_CIC));
    top_raw[`HIS_TOP_DINT] = |(d_pend & ~d_mask_q);
    top_raw[`HIS_TOP_DEXT] = |x_pend;
    top_raw[`HIS_TOP_BINT] = b_shown[`HIS_B_XPR];
    top_raw[`HIS_TOP_BEXT] = b_shown[`HIS_B_XMR] | b_shown[`HIS_B_XDU];
    top_shown = top_raw & ~top_mask_q[3:0];
  end

  always_comb
  begin
    rd_d = 32'h0000_0000;
    case (paddr)
      `HIS_A_TOP: rd_d[3:0] = top_shown;
      `HIS_A_TOPM: rd_d[7:0] = top_mask_q;
      `HIS_A_BST: rd_d[`HIS_B_XPR] = b_shown[`HIS_B_XPR];
      `HIS_A_BEX: rd_d[`HIS_B_XDU:`HIS_B_XMR] = b_shown[`HIS_B_XDU:`HIS_B_XMR];
      `HIS_A_BMSK: rd_d[7:0] = b_mask_q;
      `HIS_A_DST: rd_d[7:0] = d_shown;
      `HIS_A_DEX: rd_d[7:0] = x_pend;
      `HIS_A_DMSK: rd_d[7:0] = d_mask_q;
      `HIS_A_CI_RECEIVE_REG0: rd_d[5:0] = {ci0_q, ci0_chg, ci1_chg & ci1_vis};
      `HIS_A_CI_RECEIVE_REG1: rd_d[3:0] = ci1_q;
      `HIS_A_FEAT: rd_d[7:0] = feat_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_n <= 1'b1;
      b_tx_reset <= 1'b0;
      d_frame_abort <= 1'b0;
      d_rx_release <= 1'b0;
    end
    else
    begin
      int_n <= ~|top_shown;
      b_tx_reset <= wr_bcmd & pwdata[`HIS_C_TRANSMITTER_RESET_CMD];
      d_frame_abort <= d_abort_set;
      d_rx_release <= wr_dcmd & pwdata[`HIS_C_RMC];
    end
  end

  // built from the flags directly so the checks do not lean on the top status path
  assign irq_due = (b_shown[`HIS_B_XPR] & ~top_mask_q[`HIS_TOP_BINT])
    | ((b_shown[`HIS_B_XMR] | b_shown[`HIS_B_XDU]) & ~top_mask_q[`HIS_TOP_BEXT])
    | (|(d_pend & ~d_mask_q) & ~top_mask_q[`HIS_TOP_DINT])
    | (|x_pend & ~top_mask_q[`HIS_TOP_DEXT]);

  transmitter_reset_cmd_xpr_a: assert property (wr_bcmd && pwdata[0] |=> b_pend[0])
    else $error("pool ready missing after transmitter reset");
  send_xpr_a: assert property (b_st_q == his_pkg::HIS_TX_SEND && b_pool_empty_evt |=> b_pend[0])
    else $error("pool ready missing during open frame");
  done_xpr_a: assert property (b_st_q == his_pkg::HIS_TX_EOM && b_frame_done_evt
    && !wr_bcmd |=> b_pend[0] && b_st_q == his_pkg::HIS_TX_IDLE)
    else $error("pool ready missing at frame end");
  brep_a: assert property (b_repeat_evt |=> b_pend[1])
    else $error("b repeat flag not set");
  bund_a: assert property ($rose(b_pend[2]) |-> $past(b_st_q) == his_pkg::HIS_TX_SEND)
    else $error("b underrun outside open frame");
  mask_keep_a: assert property (rd && at(paddr, `HIS_A_DST) && d_mask_q[7] && d_flags[7]
    |=> d_flags[7])
    else $error("masked source lost on read");
  exd_mask_a: assert property (top_mask_q[1] |-> !top_shown[1]
    ##1 (int_n || $past(top_shown) != 4'h0))
    else $error("masked summary reached interrupt");
  pce_auto_a: assert property ($rose(x_pend[3]) |-> $past(auto_m))
    else $error("protocol error outside auto mode");
  dxdu_abort_a: assert property (d_abort_set |=> d_frame_abort && x_pend[6] && !d_send_q)
    else $error("d underrun without abort");
  irq_due_a: assert property (irq_due |=> !int_n)
    else $error("interrupt line idle with a source pending");
  irq_track_a: assert property (!irq_due |=> int_n)
    else $error("interrupt line disagrees with status");
endmodule

// [his_host.sv]
// host model: apb master that services the interrupt status block
`timescale 1ns/1ps
module his_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // one idle edge first, so psel never gets two values in one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // address and data lines show the inverse so stale values cannot pass
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // fifo words are pulled on another path; only the release is issued here
  task automatic release_rx();
    logic [31:0] q;
    logic e;
    xfer(1'b1, 8'h24, 32'h8, q, e);
  endtask
endmodule

// [testbench.sv]
// self-checking bench for the interrupt status block
`timescale 1ns/1ps
`include "his_regs.svh"
module testbench;
  typedef struct {
    int ev;
    logic [7:0] feat;
    logic [7:0] a;
    logic [7:0] exp;
  } his_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, int_n;
  logic b_tx_reset, d_frame_abort, d_rx_release;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [18:0] ev;
  logic [3:0] ci0, ci1;
  int pc [3];
  int err_count, checks;
  his_row_t rows [14];
  his_top u_his_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .b_pool_empty_evt(ev[0]), .b_frame_done_evt(ev[1]),
    .b_drained_evt(ev[2]), .b_repeat_evt(ev[3]),
    .d_rx_pool_full_evt(ev[4]), .d_rx_msg_end_evt(ev[5]),
    .d_rx_overflow_evt(ev[6]), .d_proto_err_evt(ev[7]),
    .d_pool_free_evt(ev[8]), .d_peer_ack_evt(ev[9]),
    .d_tx_error_evt(ev[10]), .d_peer_nack_evt(ev[11]),
    .d_fifo_empty_evt(ev[12]), .d_frame_done_evt(ev[13]),
    .d_peer_status_evt(ev[14]), .d_ext_timer_evt(ev[15]),
    .d_t200_exp(ev[16]), .d_n200_exp(ev[17]), .d_timer2_evt(ev[18]),
    .ci0_code(ci0), .ci1_code(ci1), .int_n(int_n), .b_tx_reset(b_tx_reset),
    .d_frame_abort(d_frame_abort), .d_rx_release(d_rx_release)
  );
  his_host u_his_host (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr)
  );
  always #4 pclk = ~pclk;
  // pulses are counted rather than timed, so one cycle of slack is tolerated
  always @(posedge pclk)
  begin
    if (b_tx_reset === 1'b1) pc[0]++;
    if (d_frame_abort === 1'b1) pc[1]++;
    if (d_rx_release === 1'b1) pc[2]++;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task automatic ichk(input logic e);
    chk("int_n", {31'h0, e}, {31'h0, int_n});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic pulse(input logic [18:0] m);
    @(posedge pclk);
    ev <= m;
    @(posedge pclk);
    ev <= 19'h0;
    idle(3);
  endtask
  task automatic setci(input logic [3:0] c0, input logic [3:0] c1);
    @(posedge pclk);
    ci0 <= c0;
    ci1 <= c1;
    idle(3);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    u_his_host.xfer(1'b1, a, {24'h0, d}, q, e);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] x);
    logic [31:0] q;
    logic e;
    u_his_host.xfer(1'b0, a, 32'h0, q, e);
    chk($sformatf("reg %h", a), {24'h0, x}, q);
  endtask
  task automatic tdone(input string n);
    $display("test %s done", n);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_count++;
    finish_test();
  end
  initial
  begin
    logic [31:0] q;
    logic e;
    int b;
    pclk = 1'b0;
    presetn = 1'b0;
    ev = 19'h0;
    ci0 = 4'h0;
    ci1 = 4'h0;
    rows = '{
      '{3, 8'h00, `HIS_A_BEX, 8'h02},
      '{4, 8'h00, `HIS_A_DST, 8'h80},
      '{5, 8'h00, `HIS_A_DST, 8'h40},
      '{6, 8'h00, `HIS_A_DEX, 8'h10},
      '{7, 8'h02, `HIS_A_DEX, 8'h08},
      '{7, 8'h00, `HIS_A_DEX, 8'h00},
      '{8, 8'h00, `HIS_A_DST, 8'h10},
      '{10, 8'h00, `HIS_A_DEX, 8'h80},
      '{11, 8'h02, `HIS_A_DEX, 8'h80},
      '{11, 8'h00, `HIS_A_DEX, 8'h00},
      '{14, 8'h02, `HIS_A_DST, 8'h20},
      '{14, 8'h00, `HIS_A_DST, 8'h00},
      '{15, 8'h00, `HIS_A_DST, 8'h08},
      '{18, 8'h00, `HIS_A_DST, 8'h02}
    };
    idle(6);
    presetn <= 1'b1;
    rc(`HIS_A_TOPM, 8'h00);
    rc(`HIS_A_BMSK, 8'h00);
    rc(`HIS_A_DMSK, 8'h00);
    rc(`HIS_A_FEAT, 8'h00);
    ichk(1'b1);
    u_his_host.xfer(1'b0, 8'h34, 32'h0, q, e);
    chk("pslverr", 32'h1, {31'h0, e});
    chk("err_data", 32'h0, q);
    rc(`HIS_A_BCMD, 8'h00);
    tdone("reset_and_map");
    foreach (rows[i])
    begin
      wr(`HIS_A_FEAT, rows[i].feat);
      pulse(19'h1 << rows[i].ev);
      ichk(rows[i].exp == 8'h00);
      rc(rows[i].a, rows[i].exp);
      rc(rows[i].a, 8'h00);
      ichk(1'b1);
      if (rows[i].ev inside {4, 5})
      begin
        b = pc[2];
        u_his_host.release_rx();
        idle(3);
        chk("rx_release", b + 1, pc[2]);
      end
    end
    tdone("rows");
    wr(`HIS_A_BCMD, 8'h01);
    idle(3);
    chk("b_tx_reset", 32'h1, pc[0]);
    rc(`HIS_A_BST, 8'h01);
    wr(`HIS_A_BCMD, 8'h02);
    repeat (2)
    begin
      pulse(19'h1);
      rc(`HIS_A_BST, 8'h01);
    end
    wr(`HIS_A_BCMD, 8'h04);
    pulse(19'h2);
    rc(`HIS_A_BST, 8'h01);
    wr(`HIS_A_BCMD, 8'h02);
    pulse(19'h4);
    rc(`HIS_A_BEX, 8'h04);
    wr(`HIS_A_BMSK, 8'h02);
    pulse(19'h8);
    rc(`HIS_A_BEX, 8'h00);
    ichk(1'b1);
    wr(`HIS_A_BMSK, 8'h00);
    rc(`HIS_A_BEX, 8'h02);
    tdone("b_channel");
    wr(`HIS_A_DCMD, 8'h02);
    pulse(19'h1000);
    rc(`HIS_A_DEX, 8'h40);
    chk("d_frame_abort", 32'h1, pc[1]);
    wr(`HIS_A_DCMD, 8'h02);
    pulse(19'h2000);
    pulse(19'h1000);
    rc(`HIS_A_DEX, 8'h00);
    chk("d_frame_abort", 32'h1, pc[1]);
    wr(`HIS_A_FEAT, 8'h02);
    wr(`HIS_A_DCMD, 8'h06);
    pulse(19'h200);
    rc(`HIS_A_DST, 8'h10);
    pulse(19'h30000);
    rc(`HIS_A_DST, 8'h08);
    wr(`HIS_A_DMSK, 8'h80);
    pulse(19'h10);
    rc(`HIS_A_DST, 8'h00);
    ichk(1'b1);
    rc(`HIS_A_DST, 8'h00);
    wr(`HIS_A_DMSK, 8'h00);
    rc(`HIS_A_DST, 8'h80);
    wr(`HIS_A_TOPM, 8'h02);
    pulse(19'h40);
    rc(`HIS_A_TOP, 8'h00);
    ichk(1'b1);
    wr(`HIS_A_TOPM, 8'h00);
    rc(`HIS_A_TOP, 8'h02);
    rc(`HIS_A_DEX, 8'h10);
    rc(`HIS_A_TOP, 8'h00);
    tdone("d_channel");
    wr(`HIS_A_FEAT, 8'h00);
    wr(`HIS_A_DMSK, 8'h04);
    setci(4'h3, 4'h0);
    ichk(1'b1);
    rc(`HIS_A_CI_RECEIVE_REG0, 8'h0E);
    wr(`HIS_A_DMSK, 8'h00);
    setci(4'h5, 4'h0);
    rc(`HIS_A_DST, 8'h04);
    rc(`HIS_A_DST, 8'h04);
    ichk(1'b0);
    rc(`HIS_A_CI_RECEIVE_REG0, 8'h16);
    rc(`HIS_A_DST, 8'h00);
    setci(4'h6, 4'h0);
    setci(4'h7, 4'h0);
    setci(4'h8, 4'h0);
    rc(`HIS_A_CI_RECEIVE_REG0, 8'h1A);
    rc(`HIS_A_CI_RECEIVE_REG0, 8'h22);
    rc(`HIS_A_CI_RECEIVE_REG0, 8'h20);
    wr(`HIS_A_FEAT, 8'h04);
    setci(4'h8, 4'h9);
    rc(`HIS_A_CI_RECEIVE_REG0, 8'h20);
    wr(`HIS_A_FEAT, 8'h05);
    rc(`HIS_A_CI_RECEIVE_REG0, 8'h21);
    rc(`HIS_A_CI_RECEIVE_REG1, 8'h09);
    tdone("ci");
    pulse(19'h10);
    @(posedge pclk);
    presetn <= 1'b0;
    ci0 <= 4'h0;
    ci1 <= 4'h0;
    idle(2);
    presetn <= 1'b1;
    rc(`HIS_A_DST, 8'h00);
    rc(`HIS_A_FEAT, 8'h00);
    ichk(1'b1);
    tdone("reset_mid_run");
    finish_test();
  end
endmodule
